// ### ioc_trip.sv
// Three-phase instant overcurrent decision block
// Function
// RULE1 - Mode off, peak or fundamental; off default
// RULE2 - Start percent 20 to 3000, default 200
// RULE3 - Exceeding threshold trips phase, no delay
// RULE4 - Each phase evaluated with own trip
// RULE5 - Peak magnitude derived per phase
// RULE6 - Upstream supplies fundamental RMS per phase
// RULE7 - Disable input forces all trips low
// RULE8 - Double input doubles the threshold
// RULE9 - Phase trips combined into general trip
// RULE10 - General trip is OR of phases
// RULE11 - Percent scaled by nominal, strict greater
// RULE12 - Trips registered per sample, sync reset
`timescale 1ns/1ps
module ioc_trip #(
  parameter int SAMPLE_W = ioc_pkg::SAMPLE_W,
  parameter int PEAK_WIN = 20
) (
  input  wire logic                CLK_SYS_I,        // 100 MHz clock
  input  wire logic                SYS_RST_I,        // Async reset, high
  input  wire logic                SAMPLE_CLR_I,     // Sync reset, high
  input  wire logic                SAMPLE_STB_I,     // New sample set
  input  wire ioc_pkg::ioc_phase_t SAMPLE_I,         // Signed samples
  input  wire ioc_pkg::ioc_phase_t FUND_RMS_I,       // Fundamental RMS
  input  wire logic [SAMPLE_W-1:0] NOMINAL_I,        // Nominal current
  input  wire ioc_pkg::ioc_mode_t  MODE_I,           // Operation mode
  input  wire logic [11:0]         START_PCT_I,      // Start percent
  input  wire logic                START_PCT_WE_I,   // Load start percent
  input  wire logic                DISABLE_I,        // Block input
  input  wire logic                THRESHOLD_X2_I,   // Double input
  output ioc_pkg::ioc_trip_t       PHASE_TRIP_O,     // Per-phase trips
  output logic                     ANY_PHASE_TRIP_O, // General trip
  output logic [11:0]              START_PCT_O,      // Active percent
  output ioc_pkg::ioc_phase_t      PEAK_MAG_O        // Peak magnitudes
);
  localparam int PROD_W = SAMPLE_W + 13;
  localparam int WIN_W  = $clog2(PEAK_WIN + 1);

  // The carrier structs fix the sample width, so only the package width can be served
  if (SAMPLE_W != ioc_pkg::SAMPLE_W || PEAK_WIN < 1) begin : g_param_check
    $error("ioc_trip: unsupported parameters");
  end

  logic [11:0]         start_pct;
  logic [11:0]         next_start_pct;
  logic [WIN_W-1:0]    win_cnt;
  logic [WIN_W-1:0]    next_win_cnt;
  ioc_pkg::ioc_trip_t  trip;
  ioc_pkg::ioc_trip_t  next_trip;
  logic                gen;
  logic                next_gen;
  ioc_pkg::ioc_phase_t peak;
  ioc_pkg::ioc_phase_t peak_q;
  ioc_pkg::ioc_phase_t next_peak_q;
  logic [PROD_W-1:0]   thr;
  logic                win_clr;
  logic [SAMPLE_W-1:0] meas [3];
  logic [SAMPLE_W-1:0] pk   [3];
  logic [SAMPLE_W-1:0] smp  [3];
  logic [2:0]          over;

  assign smp[0] = SAMPLE_I.a;
  assign smp[1] = SAMPLE_I.b;
  assign smp[2] = SAMPLE_I.c;
  assign win_clr = (win_cnt == '0);

  // Peak window restarts every PEAK_WIN samples, about one network period
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ph
      ioc_peak #(.W(SAMPLE_W)) u_peak ( // RULE5
        .clk_i  (CLK_SYS_I),
        .rst_i  (SYS_RST_I),
        .stb_i  (SAMPLE_STB_I),
        .samp_i (smp[g]),
        .clr_i  (win_clr),
        .peak_o (pk[g])
      );
    end
  endgenerate

  assign peak = '{a: pk[0], b: pk[1], c: pk[2]};

  // Threshold in input units: nominal * percent / 100, optionally doubled
  always_comb begin
    // Operands widened first so the product cannot wrap at the input width
    thr = PROD_W'(NOMINAL_I) * PROD_W'(start_pct) / PROD_W'(ioc_pkg::PCT_BASE); // RULE11
    if (THRESHOLD_X2_I) begin
      thr = PROD_W'({thr, 1'b0}); // RULE8
    end
  end

  always_comb begin
    meas[0] = (MODE_I == ioc_pkg::IOC_OP_PEAK) ? pk[0] : FUND_RMS_I.a; // RULE6
    meas[1] = (MODE_I == ioc_pkg::IOC_OP_PEAK) ? pk[1] : FUND_RMS_I.b;
    meas[2] = (MODE_I == ioc_pkg::IOC_OP_PEAK) ? pk[2] : FUND_RMS_I.c;
    for (int i = 0; i < 3; i++) begin
      over[i] = PROD_W'(meas[i]) > thr; // RULE11 RULE4
    end
  end

  always_comb begin
    next_start_pct = start_pct;
    // Out-of-range writes are ignored so the setting never leaves its range
    if (START_PCT_WE_I && START_PCT_I >= ioc_pkg::START_PCT_MIN
        && START_PCT_I <= ioc_pkg::START_PCT_MAX) begin
      next_start_pct = START_PCT_I; // RULE2
    end
    next_win_cnt = win_cnt;
    next_trip    = trip;
    next_gen     = gen;
    next_peak_q  = peak_q;
    if (SAMPLE_CLR_I) begin
      next_trip    = '0; // RULE12
      next_gen     = 1'b0;
      next_win_cnt = '0;
    end else if (SAMPLE_STB_I) begin
      next_win_cnt = (win_cnt == WIN_W'(PEAK_WIN - 1)) ? '0 : WIN_W'(win_cnt + 1'b1);
      next_peak_q  = peak;
      if (DISABLE_I || MODE_I == ioc_pkg::IOC_OP_OFF
          || MODE_I == ioc_pkg::ioc_mode_t'(2'h3)) begin
        next_trip = '0; // RULE1 RULE7
        next_gen  = 1'b0;
      end else begin
        next_trip = '{a: over[0], b: over[1], c: over[2]}; // RULE3
        next_gen  = |over; // RULE9 RULE10
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      start_pct <= ioc_pkg::START_PCT_RST; // RULE2
      win_cnt   <= '0;
      trip      <= '0;
      gen       <= 1'b0;
      peak_q    <= '0;
    end else begin
      start_pct <= next_start_pct;
      win_cnt   <= next_win_cnt;
      trip      <= next_trip; // RULE12
      gen       <= next_gen;
      peak_q    <= next_peak_q;
    end
  end

  assign PHASE_TRIP_O     = trip;
  assign ANY_PHASE_TRIP_O = gen;
  assign START_PCT_O      = start_pct;
  assign PEAK_MAG_O       = peak_q;

  AST_GEN_OR: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I) // RULE10
    ANY_PHASE_TRIP_O == (trip.a | trip.b | trip.c))
    else $error("general trip differs from phase OR");
  AST_BLOCK: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I) // RULE7
    DISABLE_I && SAMPLE_STB_I |=> !ANY_PHASE_TRIP_O && trip == '0)
    else $error("trip while blocked");
  AST_OFF: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I) // RULE1
    MODE_I == ioc_pkg::IOC_OP_OFF && SAMPLE_STB_I |=> trip == '0)
    else $error("trip while mode off");
  AST_TRIP_A: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I) // RULE3
    SAMPLE_STB_I && !SAMPLE_CLR_I && !DISABLE_I && MODE_I == ioc_pkg::IOC_OP_FUND
    && ({13'h0, FUND_RMS_I.a} > thr) |=> trip.a)
    else $error("phase a did not trip");
  AST_NO_TRIP_A: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I) // RULE11
    SAMPLE_STB_I && MODE_I == ioc_pkg::IOC_OP_FUND
    && ({13'h0, FUND_RMS_I.a} <= thr) |=> !trip.a)
    else $error("phase a tripped at or below threshold");
  AST_HOLD: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I) // RULE12
    !SAMPLE_STB_I && !SAMPLE_CLR_I |=> $stable(trip))
    else $error("trip changed without sample");
  AST_SCLR: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I) // RULE12
    SAMPLE_CLR_I |=> trip == '0 && !gen)
    else $error("sync clear ignored");
  AST_PCT_RANGE: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I) // RULE2
    start_pct >= ioc_pkg::START_PCT_MIN && start_pct <= ioc_pkg::START_PCT_MAX)
    else $error("start percent out of range");
  AST_PEAK: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I) // RULE5
    SAMPLE_STB_I && !win_clr |-> pk[0] >= peak_q.a)
    else $error("peak dropped inside window");

  // Steps of one decision: a set is taken, then the mode picks the quantity
  sequence s_take;
    SAMPLE_STB_I && !SAMPLE_CLR_I && !DISABLE_I;
  endsequence
  sequence s_fund_take;
    s_take ##0 (MODE_I == ioc_pkg::IOC_OP_FUND);
  endsequence
  sequence s_peak_take;
    s_take ##0 (MODE_I == ioc_pkg::IOC_OP_PEAK);
  endsequence

  AST_TRIP_B: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I) // RULE4
    s_fund_take ##0 (PROD_W'(FUND_RMS_I.b) > thr) |=> trip.b)
    else $error("phase b did not trip");
  AST_TRIP_C: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I) // RULE4
    s_fund_take ##0 (PROD_W'(FUND_RMS_I.c) > thr) |=> trip.c)
    else $error("phase c did not trip");
  AST_PEAK_TRIP: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I) // RULE5
    s_peak_take ##0 (PROD_W'(pk[1]) > thr) |=> trip.b)
    else $error("phase b ignored its peak");
  AST_PEAK_QUIET: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I) // RULE11
    s_peak_take ##0 (PROD_W'(pk[2]) <= thr) |=> !trip.c)
    else $error("phase c tripped at or below threshold");
  // Doubled threshold written out apart from the comparator path
  AST_X2_TRIP: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I) // RULE8
    s_fund_take ##0 THRESHOLD_X2_I
    ##0 (PROD_W'(FUND_RMS_I.a) > PROD_W'(NOMINAL_I) * PROD_W'(start_pct)
         / PROD_W'(ioc_pkg::PCT_BASE) * PROD_W'(2)) |=> trip.a)
    else $error("phase a did not trip on doubled threshold");
  AST_X2_QUIET: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I) // RULE8
    s_fund_take ##0 THRESHOLD_X2_I
    ##0 (PROD_W'(FUND_RMS_I.a) <= PROD_W'(NOMINAL_I) * PROD_W'(start_pct)
         / PROD_W'(ioc_pkg::PCT_BASE) * PROD_W'(2)) |=> !trip.a)
    else $error("phase a tripped below doubled threshold");
  AST_MODE3: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I) // RULE1
    SAMPLE_STB_I && MODE_I == ioc_pkg::ioc_mode_t'(2'h3) |=> trip == '0 && !gen)
    else $error("trip with unused mode code");
  AST_ANY_ROSE: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I) // RULE12
    $rose(ANY_PHASE_TRIP_O) |-> $past(SAMPLE_STB_I && !SAMPLE_CLR_I))
    else $error("general trip rose without a sample");
  AST_PCT_LOAD: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I) // RULE2
    START_PCT_WE_I && START_PCT_I >= ioc_pkg::START_PCT_MIN
    && START_PCT_I <= ioc_pkg::START_PCT_MAX |=> start_pct == $past(START_PCT_I))
    else $error("legal start percent not loaded");
  AST_PCT_KEEP: assert property (@(posedge CLK_SYS_I) disable iff (SYS_RST_I) // RULE2
    START_PCT_WE_I && (START_PCT_I < ioc_pkg::START_PCT_MIN
    || START_PCT_I > ioc_pkg::START_PCT_MAX) |=> $stable(start_pct))
    else $error("illegal start percent taken");
endmodule

// ### ioc_pkg.sv
// Package: shared constants and types of the instant overcurrent unit
package ioc_pkg;
  localparam int SAMPLE_W = 16;
  localparam int PCT_W    = 12;
  localparam logic [11:0] START_PCT_MIN = 12'h014;
  localparam logic [11:0] START_PCT_MAX = 12'hbb8;
  localparam logic [11:0] START_PCT_RST = 12'h0c8;
  localparam logic [11:0] PCT_BASE      = 12'h064;
  typedef enum logic [1:0] {
    IOC_OP_OFF  = 2'h0,
    IOC_OP_PEAK = 2'h1,
    IOC_OP_FUND = 2'h2
  } ioc_mode_t;
  typedef struct packed {
    logic [SAMPLE_W-1:0] a;
    logic [SAMPLE_W-1:0] b;
    logic [SAMPLE_W-1:0] c;
  } ioc_phase_t;
  typedef struct packed {
    logic a;
    logic b;
    logic c;
  } ioc_trip_t;
endpackage

// ### ioc_peak.sv
// Per-phase peak magnitude tracker of the sampled current
`timescale 1ns/1ps
module ioc_peak #(
  parameter int W = 16
) (
  input  wire logic         clk_i,   // System clock
  input  wire logic         rst_i,   // Async reset, high
  input  wire logic         stb_i,   // New sample strobe
  input  wire logic [W-1:0] samp_i,  // Signed sample
  input  wire logic         clr_i,   // Window restart
  output logic      [W-1:0] peak_o   // Peak magnitude
);
  logic [W-1:0] mag;
  logic [W-1:0] peak;
  logic [W-1:0] next_peak;

  always_comb begin
    mag = samp_i[W-1] ? W'(~samp_i + 1'b1) : samp_i;
    next_peak = peak;
    if (stb_i) begin
      if (clr_i || mag > peak) begin
        next_peak = mag;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      peak <= '0;
    end else begin
      peak <= next_peak;
    end
  end

  // Window includes the current sample so a fresh window never reads the previous window's peak
  assign peak_o = (stb_i && clr_i) ? mag : ((stb_i && mag > peak) ? mag : peak);
endmodule

// ### ioc_src.sv
// Front end model: presents sample sets and their fundamental magnitudes
`timescale 1ns/1ps
module ioc_src (
  input  wire logic                clk_i,  // System clock
  input  wire logic                req_i,  // Present a sample set
  input  wire ioc_pkg::ioc_phase_t set_i,  // Raw signed samples
  output logic                     stb_o,  // Sample strobe
  output ioc_pkg::ioc_phase_t      samp_o, // Samples to block
  output ioc_pkg::ioc_phase_t      fund_o  // Fundamental RMS
);
  ioc_pkg::ioc_phase_t last = '0;
  ioc_pkg::ioc_phase_t mag;
  // Steady tone stands in for the transform, so RMS equals sample size
  assign mag = {set_i.a[15] ? -set_i.a : set_i.a, set_i.b[15] ? -set_i.b : set_i.b,
                set_i.c[15] ? -set_i.c : set_i.c};
  assign stb_o = req_i;
  // Stale values are inverted so a late capture cannot pass by luck
  assign samp_o = req_i ? set_i : ~last;
  assign fund_o = req_i ? mag : ~last;
  always @(posedge clk_i) if (req_i) last <= set_i;
endmodule

// ### ioc_trip_tb.sv
// Self-checking bench of the three-phase instant overcurrent block
`timescale 1ns/1ps
module ioc_trip_tb;
  logic clk = 0, rst, clr, req, we, dis, x2, any;
  logic [15:0] nom, pk [3];
  logic [11:0] pct, pct_e, pct_o;
  logic [3:0] last_e;
  ioc_pkg::ioc_mode_t mode;
  ioc_pkg::ioc_phase_t set, samp, fund, peak;
  ioc_pkg::ioc_trip_t trip;
  logic stb;
  int n_fail, tests_run, cnt;
  logic [11:0] pv [5] = '{12'h013, 12'h014, 12'hbb8, 12'hbb9, 12'h064};
  always #5 clk = ~clk;
  ioc_src src (.clk_i(clk), .req_i(req), .set_i(set), .stb_o(stb), .samp_o(samp),
               .fund_o(fund));
  ioc_trip #(.PEAK_WIN(2)) dut (.CLK_SYS_I(clk), .SYS_RST_I(rst), .SAMPLE_CLR_I(clr),
    .SAMPLE_STB_I(stb), .SAMPLE_I(samp), .FUND_RMS_I(fund), .NOMINAL_I(nom), .MODE_I(mode),
    .START_PCT_I(pct), .START_PCT_WE_I(we), .DISABLE_I(dis), .THRESHOLD_X2_I(x2),
    .PHASE_TRIP_O(trip), .ANY_PHASE_TRIP_O(any), .START_PCT_O(pct_o), .PEAK_MAG_O(peak));
  task automatic chk_trip(input logic [3:0] e, input logic [3:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic chk_val(input logic [47:0] e, input logic [47:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  function automatic logic hit(input logic [15:0] m);
    int thr;
    thr = int'(nom) * int'(pct_e) / 100 * (x2 ? 2 : 1);
    return (mode == ioc_pkg::IOC_OP_PEAK || mode == ioc_pkg::IOC_OP_FUND) && !dis
           && int'(m) > thr;
  endfunction
  function automatic logic [15:0] rs();
    logic [15:0] v;
    v = 16'($urandom_range(0, 1100));
    return $urandom_range(0, 1) ? -v : v;
  endfunction
  // Called at a falling edge; consecutive calls give back-to-back strobes
  task automatic strobe(input logic [47:0] s);
    logic [15:0] m;
    req = 1'b1;
    set = s;
    for (int i = 0; i < 3; i++) begin
      m = s[32-16*i +: 16];
      m = m[15] ? -m : m;
      pk[i] = (cnt == 0 || m > pk[i]) ? m : pk[i];
      last_e[3-i] = hit(mode == ioc_pkg::IOC_OP_PEAK ? pk[i] : m);
    end
    cnt = (cnt + 1) % 2;
    last_e[0] = |last_e[3:1];
    @(negedge clk);
    chk_trip(last_e, {trip, any});
    chk_val({pk[0], pk[1], pk[2]}, peak);
  endtask
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #200us;
    n_fail++;
    report_and_stop();
  end
  initial begin
    {rst, clr, req, we, dis, x2} = 6'h20;
    set = '0;
    nom = 16'h0100;
    pct = 12'h000;
    mode = ioc_pkg::IOC_OP_OFF;
    pct_e = ioc_pkg::START_PCT_RST;
    n_fail = 0;
    tests_run = 0;
    cnt = 0;
    void'($urandom(32'h0411));
    repeat (4) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    chk_val(48'(pct_e), 48'(pct_o));
    chk_trip(4'h0, {trip, any});
    we = 1'b1;
    foreach (pv[i]) begin
      pct = pv[i];
      if (pv[i] >= ioc_pkg::START_PCT_MIN && pv[i] <= ioc_pkg::START_PCT_MAX) pct_e = pv[i];
      @(negedge clk);
      chk_val(48'(pct_e), 48'(pct_o));
    end
    we = 1'b0;
    for (int md = 0; md < 4; md++) for (int k = 0; k < 2; k++) begin
      mode = ioc_pkg::ioc_mode_t'(md);
      x2 = k[0];
      strobe({16'(256 << k), 16'(257 << k), -16'(257 << k)});
    end
    repeat (300) begin
      mode = ioc_pkg::ioc_mode_t'($urandom_range(0, 3));
      dis = ($urandom_range(0, 3) == 0);
      x2 = $urandom_range(0, 1);
      nom = 16'($urandom_range(64, 512));
      strobe({rs(), rs(), rs()});
    end
    mode = ioc_pkg::IOC_OP_PEAK;
    dis = 1'b0;
    strobe(48'h0fff_0fff_0fff);
    clr = 1'b1;
    @(negedge clk);
    chk_trip(4'h0, {trip, any});
    clr = 1'b0;
    cnt = 0;
    strobe(48'h0fff_0001_0002);
    req = 1'b0;
    repeat (3) @(negedge clk);
    chk_trip(last_e, {trip, any});
    report_and_stop();
  end
endmodule
